// ===== inc/dmb_params.svh
`ifndef DMB_PARAMS_SVH
`define DMB_PARAMS_SVH
// synchronised pin vector layout
`define DMB_NIN 24
`define DMB_P_CK 23
`define DMB_P_RSTN 22
`define DMB_P_CKE 21
`define DMB_P_CS 20
`define DMB_P_RAS 19
`define DMB_P_CAS 18
`define DMB_P_WE 17
`define DMB_P_ODT 16
`define DMB_P_BA_HI 15
`define DMB_P_BA_LO 13
`define DMB_P_A_HI 12
`define DMB_P_A_LO 0
`define DMB_PIN_RST 24'h000000
// commands as {ras_n, cas_n, we_n} with cs_n low
`define DMB_CMD_MRS 3'h0
`define DMB_CMD_WRITE 3'h4
`define DMB_CMD_READ 3'h5
// mode register select on ba[1:0]
`define DMB_BA_MR0 2'h0
`define DMB_BA_MR1 2'h1
`define DMB_BA_MR2 2'h2
`define DMB_BA_MR3 2'h3
// mode register fields
`define DMB_MR_RST 13'h0000
`define DMB_MR0_BL_HI 1
`define DMB_MR0_BL_LO 0
`define DMB_MR0_BT 3
`define DMB_MR0_DLLRST 8
`define DMB_MR1_DLLDIS 0
`define DMB_MR1_RTT0 2
`define DMB_MR1_RTT1 6
`define DMB_MR1_RTT2 9
`define DMB_A_BC 12
`define DMB_BL_FIX8 2'h0
`define DMB_BL_OTF 2'h1
`define DMB_BL_FIX4 2'h2
`define DMB_RTT_OFF 3'h0
`define DMB_BEAT_LAST 3'h7
`define DMB_BEAT_RST 3'h0
`define DMB_DLLK_CYC 512
`define DMB_DLL_W 16
`endif

// ===== inc/dmb_pkg.sv
`default_nettype none
package dmb_pkg;
  typedef enum logic [2:0] {
    ST_RST = 3'b001,
    ST_CKE_WAIT = 3'b010,
    ST_ACTIVE = 3'b100
  } dmb_state_t;
endpackage
`default_nettype wire

// ===== logic/dmb_burst_order.sv
`timescale 1ns/10ps
`default_nettype none
module dmb_burst_order (
  // burst setup
  input wire logic [2:0] start_col,
  input wire logic interleave,
  input wire logic chop,
  input wire logic is_write,
  input wire logic [2:0] beat,
  // result
  output logic [2:0] col,
  output logic valid
);
  always_comb begin
    col = beat;
    valid = 1'b1;
    if (is_write) begin
      if (chop) begin
        col = {start_col[2], beat[1:0]};
        valid = ~beat[2];
      end
    end else if (chop) begin
      valid = ~beat[2];
      if (interleave) begin
        col = {start_col[2], start_col[1:0] ^ beat[1:0]};
      end else begin
        col = {start_col[2], start_col[1:0] + beat[1:0]};
      end
    end else if (interleave) begin
      col = start_col ^ beat;
    end else begin
      col = {start_col[2] ^ beat[2], start_col[1:0] + beat[1:0]};
    end
  end
endmodule // dmb_burst_order
`default_nettype wire

// ===== logic/dmb_top.sv
// What this block does
// - termination off during reset and until cke is registered high
// - mode write picks register by ba1/ba0, ba2 low; the block ignores ba2 and writes the register whatever its level
// - mode writes and dll reset never disturb array contents
// - mr0 a3 selects sequential or interleaved read burst order
// - mr0 a1:a0 select chop-4, length-8 or on-the-fly via a12
// - length-8 reads follow sequential or interleaved column order
// - chop-4 reads stay in start nibble; last four beats tristate
// - chop-4 writes use start bit 2; length-8 writes columns 0 to 7
`timescale 1ns/10ps
`default_nettype none
`include "dmb_params.svh"
module dmb_top #(
  parameter int DLLK_CYC = `DMB_DLLK_CYC
) (
  // system
  input wire logic CLK_SYS,
  input wire logic RST,
  // memory pins from the controller
  input wire logic CK,
  input wire logic RESET_N,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic ODT,
  input wire logic [2:0] BA,
  input wire logic [12:0] A,
  // status
  output logic TERM_ON,
  output logic CKE_SEEN,
  output logic DLL_LOCKED,
  output logic [12:0] MR0,
  output logic [12:0] MR1,
  output logic [12:0] MR2,
  output logic [12:0] MR3,
  // burst columns
  output logic [2:0] RD_COL,
  output logic RD_VALID,
  output logic DQ_OE_N,
  output logic [2:0] WR_COL,
  output logic WR_VALID
);
  if (DLLK_CYC < 1 || DLLK_CYC >= (1 << `DMB_DLL_W)) begin : g_chk
    $error("DLLK_CYC out of range");
  end

  // pin synchroniser: the clean copy moves once stages 2 and 3 agree
  logic [`DMB_NIN-1:0] pin_raw;
  logic [`DMB_NIN-1:0] s1, s2, s3, clean, next_clean;
  assign pin_raw = {CK, RESET_N, CKE, CS_N, RAS_N, CAS_N, WE_N, ODT, BA, A};

  for (genvar g = 0; g < `DMB_NIN; g++) begin : g_sync
    always_comb begin
      next_clean[g] = (s2[g] == s3[g]) ? s3[g] : clean[g];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      s1 <= `DMB_PIN_RST;
      s2 <= `DMB_PIN_RST;
      s3 <= `DMB_PIN_RST;
      clean <= `DMB_PIN_RST;
    end else begin
      s1 <= pin_raw;
      s2 <= s1;
      s3 <= s2;
      clean <= next_clean;
    end
  end

  logic ck_prev, ck_rise, in_rst, cmd_go;
  logic [2:0] cmd;
  logic [1:0] ba_sel;
  logic [12:0] addr;
  assign ck_rise = clean[`DMB_P_CK] & ~ck_prev;
  assign in_rst = ~clean[`DMB_P_RSTN];
  assign cmd = {clean[`DMB_P_RAS], clean[`DMB_P_CAS], clean[`DMB_P_WE]};
  assign ba_sel = clean[`DMB_P_BA_LO+1:`DMB_P_BA_LO];
  assign addr = clean[`DMB_P_A_HI:`DMB_P_A_LO];

  // device state
  dmb_pkg::dmb_state_t state, next_state;
  always_comb begin
    next_state = state;
    case (state)
      dmb_pkg::ST_RST: next_state = dmb_pkg::ST_CKE_WAIT;
      dmb_pkg::ST_CKE_WAIT: begin
        if (ck_rise && clean[`DMB_P_CKE]) begin
          next_state = dmb_pkg::ST_ACTIVE;
        end
      end
      dmb_pkg::ST_ACTIVE: next_state = dmb_pkg::ST_ACTIVE;
      default: next_state = dmb_pkg::ST_RST;
    endcase
    if (in_rst) begin
      next_state = dmb_pkg::ST_RST;
    end
  end
  assign cmd_go = ck_rise && state == dmb_pkg::ST_ACTIVE &&
                  clean[`DMB_P_CKE] && !clean[`DMB_P_CS];

  // mode registers and dll lock timer
  logic [12:0] next_mr0, next_mr1, next_mr2, next_mr3;
  logic [`DMB_DLL_W-1:0] dll_cnt, next_dll_cnt;
  logic next_locked, next_term;
  always_comb begin
    next_mr0 = MR0;
    next_mr1 = MR1;
    next_mr2 = MR2;
    next_mr3 = MR3;
    next_dll_cnt = dll_cnt;
    if (ck_rise && dll_cnt != '0) begin
      next_dll_cnt = dll_cnt - 1'b1;
    end
    // only the mode registers and the dll timer change here, never stored data
    if (cmd_go && cmd == `DMB_CMD_MRS) begin
      case (ba_sel)
        `DMB_BA_MR0: begin
          next_mr0 = addr;
          // dll reset bit clears itself once acted on
          next_mr0[`DMB_MR0_DLLRST] = 1'b0;
          if (addr[`DMB_MR0_DLLRST]) begin
            next_dll_cnt = DLLK_CYC[`DMB_DLL_W-1:0];
          end
        end
        `DMB_BA_MR1: next_mr1 = addr;
        `DMB_BA_MR2: next_mr2 = addr;
        default: next_mr3 = addr;
      endcase
    end
    if (in_rst) begin
      next_mr0 = `DMB_MR_RST;
      next_mr1 = `DMB_MR_RST;
      next_mr2 = `DMB_MR_RST;
      next_mr3 = `DMB_MR_RST;
      next_dll_cnt = DLLK_CYC[`DMB_DLL_W-1:0];
    end
    next_locked = (next_dll_cnt == '0) && !next_mr1[`DMB_MR1_DLLDIS];
    // termination needs the device out of reset with cke registered high
    next_term = (next_state == dmb_pkg::ST_ACTIVE) &&
                clean[`DMB_P_ODT] &&
                ({next_mr1[`DMB_MR1_RTT2], next_mr1[`DMB_MR1_RTT1],
                  next_mr1[`DMB_MR1_RTT0]} != `DMB_RTT_OFF);
  end

  // burst sequencer: one beat per ck rise; a new command restarts
  logic busy, next_busy, b_wr, next_b_wr, b_chop, next_b_chop;
  logic b_il, next_b_il;
  logic [2:0] b_col, next_b_col, beat, next_beat, ord_col;
  logic ord_valid;
  always_comb begin
    next_busy = busy;
    next_b_wr = b_wr;
    next_b_chop = b_chop;
    next_b_il = b_il;
    next_b_col = b_col;
    next_beat = beat;
    if (ck_rise && busy) begin
      next_beat = beat + 1'b1;
      if (beat == `DMB_BEAT_LAST) begin
        next_busy = 1'b0;
      end
    end
    if (cmd_go && (cmd == `DMB_CMD_READ || cmd == `DMB_CMD_WRITE)) begin
      next_busy = 1'b1;
      next_beat = `DMB_BEAT_RST;
      next_b_wr = (cmd == `DMB_CMD_WRITE);
      next_b_col = addr[2:0];
      next_b_il = MR0[`DMB_MR0_BT];
      case (MR0[`DMB_MR0_BL_HI:`DMB_MR0_BL_LO])
        `DMB_BL_FIX8: next_b_chop = 1'b0;
        `DMB_BL_OTF: next_b_chop = ~addr[`DMB_A_BC];
        `DMB_BL_FIX4: next_b_chop = 1'b1;
        default: next_b_chop = 1'b0;
      endcase
    end
    if (in_rst) begin
      next_busy = 1'b0;
      next_beat = `DMB_BEAT_RST;
    end
  end

  dmb_burst_order u_order (
    .start_col(b_col),
    .interleave(b_il),
    .chop(b_chop),
    .is_write(b_wr),
    .beat(beat),
    .col(ord_col),
    .valid(ord_valid)
  );

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ck_prev <= 1'b0;
      state <= dmb_pkg::ST_RST;
      MR0 <= `DMB_MR_RST;
      MR1 <= `DMB_MR_RST;
      MR2 <= `DMB_MR_RST;
      MR3 <= `DMB_MR_RST;
      dll_cnt <= DLLK_CYC[`DMB_DLL_W-1:0];
      DLL_LOCKED <= 1'b0;
      TERM_ON <= 1'b0;
      CKE_SEEN <= 1'b0;
      busy <= 1'b0;
      b_wr <= 1'b0;
      b_chop <= 1'b0;
      b_il <= 1'b0;
      b_col <= `DMB_BEAT_RST;
      beat <= `DMB_BEAT_RST;
      RD_COL <= `DMB_BEAT_RST;
      RD_VALID <= 1'b0;
      DQ_OE_N <= 1'b1;
      WR_COL <= `DMB_BEAT_RST;
      WR_VALID <= 1'b0;
    end else begin
      ck_prev <= clean[`DMB_P_CK];
      state <= next_state;
      MR0 <= next_mr0;
      MR1 <= next_mr1;
      MR2 <= next_mr2;
      MR3 <= next_mr3;
      dll_cnt <= next_dll_cnt;
      DLL_LOCKED <= next_locked;
      TERM_ON <= next_term;
      CKE_SEEN <= (next_state == dmb_pkg::ST_ACTIVE);
      busy <= next_busy;
      b_wr <= next_b_wr;
      b_chop <= next_b_chop;
      b_il <= next_b_il;
      b_col <= next_b_col;
      beat <= next_beat;
      // tristate beats of a chop read leave the driver off
      RD_COL <= ord_col;
      RD_VALID <= busy && !b_wr && ord_valid;
      DQ_OE_N <= !(busy && !b_wr && ord_valid);
      WR_COL <= ord_col;
      WR_VALID <= busy && b_wr && ord_valid;
    end
  end
endmodule // dmb_top
`default_nettype wire

// ===== bench/dmb_properties.sv
`timescale 1ns/10ps
`default_nettype none
module dmb_properties (
  // system
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic RESET_N,
  // status
  input wire logic TERM_ON,
  input wire logic CKE_SEEN,
  input wire logic DLL_LOCKED,
  input wire logic [12:0] MR0,
  input wire logic [12:0] MR1,
  // bursts
  input wire logic [2:0] RD_COL,
  input wire logic RD_VALID,
  input wire logic DQ_OE_N,
  input wire logic [2:0] WR_COL,
  input wire logic WR_VALID
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence rd_step;
    RD_VALID && $past(RD_VALID) && $changed(RD_COL);
  endsequence
  sequence wr_step;
    WR_VALID && $past(WR_VALID) && $changed(WR_COL);
  endsequence
  a_term_reset: assert property (
    !RESET_N [*8] |-> !TERM_ON && !CKE_SEEN) else $error("term in reset");
  a_term_cke: assert property (
    !CKE_SEEN |-> !TERM_ON) else $error("term before cke");
  a_oe_follows: assert property (
    DQ_OE_N == !RD_VALID) else $error("oe not tied to beat");
  a_dll_needs_on: assert property (
    DLL_LOCKED |-> !MR1[0]) else $error("lock with dll off");
  a_dll_rst_clear: assert property (
    MR0[8] == 1'b0) else $error("dll reset bit stuck");
  a_rd_seq: assert property (
    rd_step |-> MR0[3] || RD_COL[1:0] == $past(RD_COL[1:0]) + 2'h1)
    else $error("sequential order");
  a_rd_flip: assert property (
    rd_step |-> RD_COL[0] != $past(RD_COL[0])) else $error("bit0 order");
  a_wr_order: assert property (
    wr_step |-> WR_COL == $past(WR_COL) + 3'h1) else $error("write order");
endmodule // dmb_properties
`default_nettype wire

// ===== bench/dmb_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module dmb_ctrl_model (
  // sampling
  input wire logic clk,
  input wire logic [8:0] obs,
  output logic [8:0] cap,
  // memory pins
  output logic ck,
  output logic reset_n,
  output logic cke,
  output logic odt,
  output logic [3:0] cmd,
  output logic [2:0] ba,
  output logic [12:0] a
);
  initial begin
    {ck, reset_n, cke, odt, ba, a, cap} = '0;
    cmd = 4'hf;
  end
  task automatic lvl(input logic r, input logic k, input logic o);
    @(negedge clk);
    {reset_n, cke, odt} = {r, k, o};
  endtask
  // ck only runs inside a slot, so idle time shows a still clock
  task automatic tick(input logic [3:0] c, input logic [2:0] b,
                      input logic [12:0] d);
    @(negedge clk);
    ck = 1'b0;
    cmd = c;
    ba = c[3] ? ~ba : b;
    a = c[3] ? ~a : d;
    repeat (4) @(negedge clk);
    ck = 1'b1;
    repeat (2) @(negedge clk);
    cap = obs;
    @(negedge clk);
  endtask
endmodule // dmb_ctrl_model
`default_nettype wire

// ===== bench/tb_dmb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "dmb_params.svh"
module tb_dmb_top;
  // short lock count keeps the run brief
  localparam int DLLK = 4;
  logic clk_sys;
  logic rst;
  logic [12:0] mv;
  int err_total;
  int n_checks;
  wire logic ck, rstn, cke, odt, term_on, cke_seen, dll_locked;
  wire logic rd_valid, oe_n, wr_valid;
  wire logic [3:0] cmd;
  wire logic [2:0] ba, rd_col, wr_col;
  wire logic [12:0] a, mr0, mr1, mr2, mr3;
  wire logic [8:0] cap;
  dmb_top #(.DLLK_CYC(DLLK)) dut_u (
    .CLK_SYS(clk_sys), .RST(rst), .CK(ck), .RESET_N(rstn), .CKE(cke),
    .CS_N(cmd[3]), .RAS_N(cmd[2]), .CAS_N(cmd[1]), .WE_N(cmd[0]),
    .ODT(odt), .BA(ba), .A(a), .TERM_ON(term_on), .CKE_SEEN(cke_seen),
    .DLL_LOCKED(dll_locked), .MR0(mr0), .MR1(mr1), .MR2(mr2), .MR3(mr3),
    .RD_COL(rd_col), .RD_VALID(rd_valid), .DQ_OE_N(oe_n),
    .WR_COL(wr_col), .WR_VALID(wr_valid));
  dmb_ctrl_model m_u (
    .clk(clk_sys), .obs({rd_valid, oe_n, rd_col, wr_valid, wr_col}),
    .cap(cap), .ck(ck), .reset_n(rstn), .cke(cke), .odt(odt), .cmd(cmd),
    .ba(ba), .a(a));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [12:0] g, input logic [12:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic finish_test;
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic nop(input int n);
    repeat (n) m_u.tick(4'hf, 3'h0, 13'h0);
  endtask
  task automatic mrs(input logic [1:0] r, input logic [12:0] v, input int n);
    m_u.tick({1'b0, `DMB_CMD_MRS}, {1'b0, r}, v);
    nop(n);
  endtask
  task automatic burst(input logic w, input logic [2:0] c, input logic bc,
                       input logic ch, input logic il);
    logic [2:0] k;
    logic [2:0] e;
    logic v;
    m_u.tick({1'b0, w ? `DMB_CMD_WRITE : `DMB_CMD_READ}, 3'h0,
             {bc, 9'h0, c});
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      v = !ch || !k[2];
      e = w ? (ch ? {c[2], k[1:0]} : k)
            : (il ? c ^ k : {c[2] ^ k[2], c[1:0] + k[1:0]});
      nop(1);
      if (w) begin
        chk(13'(cap[3]), 13'(v));
        if (v) chk(13'(cap[2:0]), 13'(e));
        // no read beat and no driver while a write runs
        chk(13'(cap[8:7]), 13'h1);
      end else begin
        chk(13'(cap[3]), 13'h0);
        chk(13'(cap[8:7]), 13'({v, !v}));
        if (v) chk(13'(cap[6:4]), 13'(e));
      end
    end
  endtask
  initial begin
    rst = 1'b1;
    mv = 13'h0;
    err_total = 0;
    n_checks = 0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    for (int p = 0; p < 2; p++) begin
      // odt left high around reset to prove it is ignored
      m_u.lvl(1'b0, 1'b0, 1'b1);
      nop(2);
      chk(13'({term_on, cke_seen, dll_locked}), 13'h0);
      chk(mr1, 13'h0);
      m_u.lvl(1'b1, 1'b0, 1'b1);
      nop(6);
      chk(13'({term_on, cke_seen}), 13'h0);
      m_u.lvl(1'b1, 1'b0, 1'b0);
      m_u.lvl(1'b1, 1'b1, 1'b0);
      nop(6);
      chk(13'(cke_seen), 13'h1);
      mrs(2'h2, 13'h0208, 4);
      mrs(2'h3, 13'h0004, 4);
      mrs(2'h1, 13'h0044, 4);
      mrs(2'h0, 13'h0310, 1);
      chk(13'(dll_locked), 13'h0);
      m_u.tick(4'h6, 3'h0, 13'h0400);
      nop(6);
      chk(13'(dll_locked), 13'h1);
      chk(mr2, 13'h0208);
      chk(mr3, 13'h0004);
      chk(mr1, 13'h0044);
      chk(mr0, 13'h0210);
      m_u.lvl(1'b1, 1'b1, 1'b1);
      nop(1);
      chk(13'(term_on), 13'h1);
      m_u.lvl(1'b1, 1'b1, 1'b0);
      nop(1);
      // termination must drop again once odt goes low
      chk(13'(term_on), 13'h0);
      for (int m = 0; m < 8; m++) begin
        mv = {4'h1, 5'h0, m[0], 1'b0, m[1] & !m[2], m[2]};
        mrs(2'h0, mv, 4);
        chk(mr0, mv);
        for (int c = 0; c < 16; c++) begin
          burst(c[3], 3'(c), m[1] ^ m[2], m[1], m[0]);
        end
      end
    end
    finish_test;
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    finish_test;
  end
endmodule // tb_dmb_top
bind dmb_top dmb_properties chk_u (
  .CLK_SYS(CLK_SYS), .RST(RST), .RESET_N(RESET_N), .TERM_ON(TERM_ON),
  .CKE_SEEN(CKE_SEEN), .DLL_LOCKED(DLL_LOCKED), .MR0(MR0), .MR1(MR1),
  .RD_COL(RD_COL), .RD_VALID(RD_VALID), .DQ_OE_N(DQ_OE_N),
  .WR_COL(WR_COL), .WR_VALID(WR_VALID));
`default_nettype wire
